// ===== rtl/uw_irq_wake.sv
// Serial port interrupt request, address detect qualification and pin wake-up
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module uw_irq_wake
  import uw_pkg::*;
#(
  parameter int RESTART_CYCLES = UW_RESTART_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver and transmitter core
  input wire uw_rx_word_type rx_word,
  input wire logic tx_empty,
  input wire logic tx_idle,
  input wire logic serial_pin,
  output logic port_run,
  output logic [7:0] baud_rate_divider,
  // Processor side
  input wire logic port_clock_off,
  input wire logic stack_full,
  output logic irq_req_b,
  output logic vector_take,
  output logic wake_up
);

  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, baud_q, irqctl_q;
  logic rx_data_available_flag_q, overrun_q, status_seen_q;
  logic [8:0] data_q;
  logic [31:0] prdata_q;
  logic pin_q, clk_off_q, wake_pend_q, cond_q, irq_pulse_q;
  logic [UW_CNT_W-1:0] cnt_q;
  uw_wake_state_type state_q, state_d;

  // Bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire sel_status = paddr == UW_OFS_STATUS;
  wire sel_ctrl1 = paddr == UW_OFS_CTRL1;
  wire sel_ctrl2 = paddr == UW_OFS_CTRL2;
  wire sel_ctrl3 = paddr == UW_OFS_CTRL3;
  wire sel_data = paddr == UW_OFS_DATA;
  wire sel_baud = paddr == UW_OFS_BAUD;
  wire sel_irqctl = paddr == UW_OFS_IRQCTL;
  wire mapped = sel_status | sel_ctrl1 | sel_ctrl2 | sel_ctrl3 | sel_data | sel_baud
    | sel_irqctl;
  wire wr_ok = access & pwrite & mapped;
  wire rd_status = access & ~pwrite & sel_status;
  wire rd_data = access & ~pwrite & sel_data;

  // Control bits
  wire port_enable = ctrl1_q[UW_C1_PORT_EN];
  wire word_length_select = ctrl1_q[UW_C1_WORD_LEN];
  wire tx_empty_ie = ctrl2_q[UW_C2_TX_EMPTY_IE];
  wire tx_idle_ie = ctrl2_q[UW_C2_TX_IDLE_IE];
  wire rx_irq_enable = ctrl2_q[UW_C2_RX_IE];
  wire addr_detect_enable = ctrl2_q[UW_C2_ADDR_DET];
  wire wake_enable = ctrl2_q[UW_C2_WAKE_EN];
  wire receiver_enable = ctrl2_q[UW_C2_RX_EN];
  wire global_irq_enable = irqctl_q[UW_IC_GLOBAL];
  wire port_irq_enable = irqctl_q[UW_IC_PORT];
  wire irq_open = global_irq_enable & port_irq_enable;

  assign port_run = ~port_clock_off;

  wire rx_take = rx_word.valid & port_run & (state_q != UW_RESTART);
  wire rx_overrun_evt = rx_take & rx_data_available_flag_q;
  wire rx_store = rx_take & ~rx_data_available_flag_q;

  wire [8:0] rx_masked = word_length_select ? rx_word.data : {1'b0, rx_word.data[7:0]};
  wire top_bit = word_length_select ? rx_word.data[8] : rx_word.data[7];

  wire addr_ok = ~addr_detect_enable | top_bit;
  wire addr_irq = addr_detect_enable & top_bit & irq_open;
  wire data_irq = ~addr_detect_enable;
  wire rx_avail_evt = rx_store & rx_irq_enable & addr_ok & (data_irq | addr_irq);
  wire ovr_evt = rx_overrun_evt & rx_irq_enable;

  // Pin falling edge while stopped
  wire pin_fall = pin_q & ~serial_pin;
  wire arm_ok = wake_enable & port_enable & receiver_enable & rx_irq_enable;
  wire enter_off = port_clock_off & ~clk_off_q;
  wire cnt_done = cnt_q == '0;
  wire wake_irq = (state_q == UW_RESTART) & cnt_done & wake_pend_q;

  wire tx_term = (tx_empty & tx_empty_ie) | (tx_idle & tx_idle_ie);
  wire cond = tx_term | rx_avail_evt | ovr_evt | wake_irq;
  wire cond_rise = cond & ~cond_q;

  // Wake sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      UW_RUN: begin
        if (enter_off & arm_ok) begin
          state_d = UW_ARMED;
        end
      end
      UW_ARMED: begin
        if (pin_fall) begin
          state_d = UW_RESTART;
        end else if (!port_clock_off) begin
          state_d = UW_RUN;
        end
      end
      UW_RESTART: begin
        if (cnt_done) begin
          state_d = UW_RUN;
        end
      end
      default: state_d = UW_RUN;
    endcase
  end

  wire wake_edge = (state_q == UW_ARMED) & pin_fall;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= UW_RUN;
      cnt_q <= '0;
      wake_pend_q <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_up <= wake_edge;
      if (wake_edge) begin
        cnt_q <= UW_CNT_W'(RESTART_CYCLES - 1);
        wake_pend_q <= irq_open;
      end else if (state_q == UW_RESTART && !cnt_done) begin
        cnt_q <= cnt_q - 1'b1;
      end else if (state_q != UW_RESTART) begin
        wake_pend_q <= 1'b0;
      end
    end
  end

  // Edge history
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
      clk_off_q <= 1'b0;
      cond_q <= 1'b0;
      irq_pulse_q <= 1'b0;
    end else begin
      pin_q <= serial_pin;
      clk_off_q <= port_clock_off;
      cond_q <= cond;
      irq_pulse_q <= cond_rise & irq_open;
    end
  end

  assign irq_req_b = ~irq_pulse_q;
  assign vector_take = irq_pulse_q & irq_open & ~stack_full;

  // Receive flags; a new word wins over a clearing read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_data_available_flag_q <= 1'b0;
      overrun_q <= 1'b0;
      status_seen_q <= 1'b0;
      data_q <= '0;
    end else begin
      if (rd_data) begin
        status_seen_q <= 1'b0;
      end else if (rd_status) begin
        status_seen_q <= 1'b1;
      end
      if (rx_store) begin
        rx_data_available_flag_q <= 1'b1;
        data_q <= rx_masked;
      end else if (rd_data && status_seen_q) begin
        rx_data_available_flag_q <= 1'b0;
      end
      if (rx_overrun_evt) begin
        overrun_q <= 1'b1;
      end else if (rd_data && status_seen_q) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl1_q <= UW_CTRL_RST;
      ctrl2_q <= UW_CTRL_RST;
      ctrl3_q <= UW_CTRL_RST;
      baud_q <= UW_BAUD_RST;
      irqctl_q <= UW_CTRL_RST;
    end else if (wr_ok) begin
      if (sel_ctrl1) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (sel_ctrl2) begin
        ctrl2_q <= pwdata[7:0];
      end
      if (sel_ctrl3) begin
        ctrl3_q <= pwdata[7:0];
      end
      if (sel_baud) begin
        baud_q <= pwdata[7:0];
      end
      if (sel_irqctl) begin
        irqctl_q <= pwdata[7:0];
      end
    end
  end

  assign baud_rate_divider = baud_q;

  // Read mux; status is read-only, writes to it are dropped
  // Word landing at the setup edge is forwarded, else the clear would lose it
  wire [7:0] status_v = {4'h0, overrun_q, rx_data_available_flag_q, tx_idle, tx_empty};
  wire [31:0] rd_mux = sel_status ? {24'h0, status_v} :
                       sel_ctrl1 ? {24'h0, ctrl1_q} :
                       sel_ctrl2 ? {24'h0, ctrl2_q} :
                       sel_ctrl3 ? {24'h0, ctrl3_q} :
                       sel_data ? {23'h0, rx_store ? rx_masked : data_q} :
                       sel_baud ? {24'h0, baud_q} :
                       sel_irqctl ? {24'h0, irqctl_q} : 32'h0;

  // Read data latched in setup so the access phase needs no wait
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Checks
  property p_irq_pulse;
    @(posedge mclk) disable iff (!rst_b)
      !irq_req_b |=> irq_req_b;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request low too long");

  property p_irq_gated;
    @(posedge mclk) disable iff (!rst_b)
      !irq_req_b |-> $past(irq_open);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("request while masked");

  property p_vector;
    @(posedge mclk) disable iff (!rst_b)
      vector_take |-> !irq_req_b && !stack_full && global_irq_enable;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector entry");

  property p_addr_block;
    @(posedge mclk) disable iff (!rst_b)
      rx_store && addr_detect_enable && !top_bit && !tx_term && !cond_q |=> irq_req_b;
  endproperty
  a_addr_block: assert property (p_addr_block) else $error("data word interrupted");

  property p_plain_rx;
    @(posedge mclk) disable iff (!rst_b)
      rx_store && !addr_detect_enable && rx_irq_enable && irq_open && !cond_q
        |=> !irq_req_b;
  endproperty
  a_plain_rx: assert property (p_plain_rx) else $error("word lost interrupt");

  property p_rx_data_available_flag_hold;
    @(posedge mclk) disable iff (!rst_b)
      rx_data_available_flag_q && !(rd_data && status_seen_q) |=> rx_data_available_flag_q;
  endproperty
  a_rx_data_available_flag_hold: assert property (p_rx_data_available_flag_hold) else $error("flag cleared early");

  property p_discard;
    @(posedge mclk) disable iff (!rst_b)
      state_q == UW_RESTART && !rx_data_available_flag_q |=> !rx_data_available_flag_q;
  endproperty
  a_discard: assert property (p_discard) else $error("word kept in restart");

  property p_wake_arm;
    @(posedge mclk) disable iff (!rst_b)
      wake_up |-> $past(state_q == UW_ARMED, 1) && $past(pin_fall);
  endproperty
  a_wake_arm: assert property (p_wake_arm) else $error("unarmed wake");

  property p_wake_wait;
    @(posedge mclk) disable iff (!rst_b)
      state_q == UW_RESTART && !cnt_done |-> !wake_irq;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("early wake irq");

endmodule : uw_irq_wake
`default_nettype wire

// ===== common/uw_pkg.sv
// Package for the serial port interrupt, address detect and wake-up block
package uw_pkg;
  // Register byte offsets
  localparam logic [7:0] UW_OFS_STATUS = 8'h00;
  localparam logic [7:0] UW_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] UW_OFS_CTRL2 = 8'h08;
  localparam logic [7:0] UW_OFS_CTRL3 = 8'h0c;
  localparam logic [7:0] UW_OFS_DATA = 8'h10;
  localparam logic [7:0] UW_OFS_BAUD = 8'h14;
  localparam logic [7:0] UW_OFS_IRQCTL = 8'h18;
  // Status fields
  localparam int UW_ST_TX_EMPTY = 0;
  localparam int UW_ST_TX_IDLE = 1;
  localparam int UW_ST_RX_DATA_AVAILABLE_FLAG = 2;
  localparam int UW_ST_OVERRUN = 3;
  // Control 1 fields
  localparam int UW_C1_PORT_EN = 0;
  localparam int UW_C1_WORD_LEN = 1;
  localparam int UW_C1_PARITY_EN = 2;
  // Control 2 fields
  localparam int UW_C2_TX_EMPTY_IE = 0;
  localparam int UW_C2_TX_IDLE_IE = 1;
  localparam int UW_C2_RX_IE = 2;
  localparam int UW_C2_ADDR_DET = 3;
  localparam int UW_C2_WAKE_EN = 4;
  localparam int UW_C2_RX_EN = 5;
  // Interrupt control fields
  localparam int UW_IC_GLOBAL = 0;
  localparam int UW_IC_PORT = 1;
  // Reset values
  localparam logic [7:0] UW_CTRL_RST = 8'h00;
  localparam logic [7:0] UW_BAUD_RST = 8'h00;
  // Post-wake restart interval
  localparam int UW_CLK_MHZ = 200;
  localparam int UW_RESTART_NS = 1000;
  localparam int UW_RESTART_CYC = (UW_RESTART_NS * UW_CLK_MHZ) / 1000;
  localparam int UW_CNT_W = 16;

  typedef struct packed {
    logic valid;
    logic [8:0] data;
  } uw_rx_word_type;

  typedef enum logic [2:0] {
    UW_RUN = 3'b001,
    UW_ARMED = 3'b010,
    UW_RESTART = 3'b100
  } uw_wake_state_type;
endpackage : uw_pkg

// ===== verification/uw_core_model.sv
// Behavioural receiver core and serial line model
`timescale 1ns/10ps
`default_nettype none
module uw_core_model
  import uw_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Commands from bench
  input wire logic snd,
  input wire logic [8:0] snd_data,
  input wire logic fall,
  // Toward block
  output uw_rx_word_type rx_word,
  output logic serial_pin
);
  initial begin
    rx_word = '0;
    serial_pin = 1'b1;
  end
  // no word in flight at sleep
  always @(posedge mclk) begin
    rx_word.valid <= snd;
    // Stale data toggles so it is never mistaken for a word
    rx_word.data <= snd ? snd_data : ~rx_word.data;
    serial_pin <= ~fall;
  end
endmodule : uw_core_model
`default_nettype wire

// ===== verification/tb_uw_irq_wake.sv
// Self-checking bench for the interrupt, address detect and wake-up block
`timescale 1ns/10ps
`default_nettype none
module tb_uw_irq_wake;
  import uw_pkg::*;
  localparam int RC = 4;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, bdiv, b;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, port_run, irq_req_b, vector_take, wake_up, serial_pin;
  logic tx_empty = 0, tx_idle = 0, clk_off = 0, stack_full = 0, snd = 0, fall = 0;
  logic [8:0] snd_data = '0, d, d1;
  logic e, se;
  uw_rx_word_type rx_word;
  int err_count = 0, total_checks = 0, lo, vt, wk;
  logic [7:0] c1s [4] = '{8'h01, 8'h03, 8'h01, 8'h03};
  logic [7:0] c2s [4] = '{8'h24, 8'h2c, 8'h2c, 8'h20};

  uw_irq_wake #(.RESTART_CYCLES(RC)) u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_word(rx_word), .tx_empty(tx_empty),
    .tx_idle(tx_idle), .serial_pin(serial_pin), .port_run(port_run),
    .baud_rate_divider(bdiv), .port_clock_off(clk_off), .stack_full(stack_full),
    .irq_req_b(irq_req_b), .vector_take(vector_take), .wake_up(wake_up));
  uw_core_model u_model (.mclk(mclk), .snd(snd), .snd_data(snd_data), .fall(fall),
    .rx_word(rx_word), .serial_pin(serial_pin));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic exp_irq(input logic [7:0] c1, c2, input logic [8:0] w);
    return c2[UW_C2_RX_IE] & (~c2[UW_C2_ADDR_DET] | (c1[UW_C1_WORD_LEN] ? w[8] : w[7]));
  endfunction : exp_irq

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic watch(input int n);
    lo = 0;
    vt = 0;
    wk = 0;
    repeat (n) begin
      @(posedge mclk);
      lo += int'(irq_req_b === 1'b0);
      vt += int'(vector_take === 1'b1);
      wk += int'(wake_up === 1'b1);
    end
  endtask : watch

  task automatic send(input logic [8:0] w);
    @(posedge mclk);
    snd <= 1;
    snd_data <= w;
    @(posedge mclk);
    snd <= 0;
    watch(8);
  endtask : send

  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(72848));
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    chk(irq_req_b, 1);
    apb(0, UW_OFS_CTRL2, 0);
    chk(rd, UW_CTRL_RST);
    apb(1, 8'h1c, 32'hff);
    chk(se, 1);
    apb(1, UW_OFS_IRQCTL, 32'h3);
    b = 8'($urandom);
    apb(1, UW_OFS_BAUD, {24'h0, b});
    for (int i = 0; i < 4; i++) begin
      apb(1, UW_OFS_CTRL1, c1s[i]);
      apb(1, UW_OFS_CTRL2, c2s[i]);
      for (int k = 0; k < 4; k++) begin
        d = 9'($urandom);
        if (c1s[i][1]) d[8] = k[0];
        else d[7] = k[0];
        e = exp_irq(c1s[i], c2s[i], d);
        stack_full <= k[1];
        send(d);
        chk(lo, e);
        chk(vt, e & ~k[1]);
        apb(1, UW_OFS_STATUS, 0);
        apb(0, UW_OFS_STATUS, 0);
        chk(rd[UW_ST_RX_DATA_AVAILABLE_FLAG], 1);
        apb(0, UW_OFS_DATA, 0);
        chk(rd, {23'h0, c1s[i][1] ? d : {1'b0, d[7:0]}});
        apb(0, UW_OFS_STATUS, 0);
        chk(rd[UW_ST_RX_DATA_AVAILABLE_FLAG], 0);
      end
    end
    stack_full <= 0;
    apb(1, UW_OFS_CTRL2, 32'h24);
    d1 = 9'($urandom);
    send(d1);
    send(~d1);
    chk(lo, 1);
    apb(0, UW_OFS_STATUS, 0);
    chk(rd[UW_ST_OVERRUN], 1);
    apb(0, UW_OFS_DATA, 0);
    chk(rd, {23'h0, d1});
    apb(0, UW_OFS_STATUS, 0);
    chk(rd[3:2], 0);
    apb(1, UW_OFS_CTRL2, 32'h1);
    tx_empty <= 1;
    watch(8);
    chk(lo, 1);
    tx_idle <= 1;
    watch(8);
    chk(lo, 0);
    // Idle source stays masked once empty drops
    tx_empty <= 0;
    watch(8);
    chk(lo, 0);
    apb(1, UW_OFS_CTRL2, 32'h2);
    watch(8);
    chk(lo, 1);
    tx_idle <= 0;
    apb(1, UW_OFS_CTRL2, 32'h34);
    for (int j = 0; j < 2; j++) begin
      apb(1, UW_OFS_IRQCTL, j ? 32'h0 : 32'h3);
      clk_off <= 1;
      repeat (3) @(posedge mclk);
      chk(port_run, 0);
      fall <= 1;
      watch(4);
      chk(wk, 1);
      chk(lo, 0);
      clk_off <= 0;
      // Word offered on the last restart edge must be dropped
      snd <= 1;
      @(posedge mclk);
      snd <= 0;
      watch(15);
      chk(lo, j ? 0 : 1);
      fall <= 0;
      apb(0, UW_OFS_STATUS, 0);
      chk(rd[UW_ST_RX_DATA_AVAILABLE_FLAG], 0);
      apb(0, UW_OFS_CTRL2, 0);
      chk(rd, 32'h34);
    end
    chk(bdiv, b);
    stop_test();
  end
endmodule : tb_uw_irq_wake
`default_nettype wire
